/* File: pkg/ablm_defs.svh */
`ifndef ABLM_DEFS_SVH
`define ABLM_DEFS_SVH
// ----------------------------------------
// Register addresses (word addresses)
// ----------------------------------------
`define ABLM_ADDR_STATUS 8'h04
`define ABLM_ADDR_ALT 8'h0B
`define ABLM_ADDR_LIMIT_A 8'h16
`define ABLM_ADDR_OFS_A0 8'h18
`define ABLM_ADDR_LIMIT_B 8'h1C
`define ABLM_ADDR_OFS_B0 8'h1E
`define ABLM_ADDR_MATH 8'h58
// ----------------------------------------
// Field positions and codes
// ----------------------------------------
`define ABLM_THR_MSB 13
`define ABLM_CNT_LSB 14
`define ABLM_ALT1_LSB 8
`define ABLM_ALT_SLOT_A 5'h10
`define ABLM_ALT_SLOT_B 5'h1A
`define ABLM_ALT_ALL 5'h1B
`define ABLM_ALT_ALL_INT 5'h1C
`define ABLM_LIM_CODE2 5'h04
`define ABLM_LIM_CODE3 5'h10
// Subtract positions of the four-pulse sequence (1 and 4)
`define ABLM_SUB_MASK 4'h9
// ----------------------------------------
// Reset values
// ----------------------------------------
`define ABLM_RST_WORD 16'h0000
`define ABLM_RST_MATH 16'h0544
`endif

/* File: pkg/ablm_pkg.sv */
package ablm_pkg;
  typedef enum logic [1:0] {ABLM_NEVER, ABLM_ONCE, ABLM_FOUR, ABLM_SIXTEEN} ablm_limit_t;
  typedef logic [4:0] ablm_count_t;
endpackage : ablm_pkg

/* File: pkg/ablm_flag_if.sv */
`timescale 1ns/1ps
interface ablm_flag_if;
  logic [7:0] flags;
  logic irq;
  logic [15:0] alt_sel;
  logic pin0;
  logic pin1;
  modport core (output flags, output irq, output alt_sel, input pin0, input pin1);
  modport mux (input flags, input irq, input alt_sel, output pin0, output pin1);
endinterface : ablm_flag_if

/* File: logic/ablm_pin_mux.sv */
`timescale 1ns/1ps
`include "ablm_defs.svh"
module ablm_pin_mux
  import ablm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  ablm_flag_if.mux fi
);
  // Decode one alternate selector against the flags
  function automatic logic alt_level(input logic [4:0] sel, input logic [7:0] f, input logic i);
    logic r;
    r = 1'b0;
    unique case (sel)
      `ABLM_ALT_SLOT_A: r = |f[3:0];
      `ABLM_ALT_SLOT_B: r = |f[7:4];
      `ABLM_ALT_ALL: r = |f;
      `ABLM_ALT_ALL_INT: r = (|f) | i;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : alt_level

  // Registered pin levels
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fi.pin0 <= 1'b0;
      fi.pin1 <= 1'b0;
    end else begin
      fi.pin0 <= alt_level(fi.alt_sel[4:0], fi.flags, fi.irq); // R10
      fi.pin1 <= alt_level(fi.alt_sel[`ABLM_ALT1_LSB +: 5], fi.flags, fi.irq); // R11
    end
  end
endmodule : ablm_pin_mux

/* File: logic/ablm_monitor.sv */
// Functional notes
// R1 - Monitor ambient automatically during float LED mode
// R2 - Compare only on LED-masked subtract cycles
// R3 - Compared value is raw minus channel offset
// R4 - Per-channel counter increments when above threshold
// R5 - Set flag when counter reaches limit
// R6 - Limit codes: never, 1, 4, 16
// R7 - Flags 3:0 slot A, 7:4 slot B
// R8 - Status flags clear when read
// R9 - Threshold low 14, count top 2 bits
// R10 - Pin 0 selector ORs chosen flags
// R11 - Pin 1 selector in bits 12:8
// R12 - Host polls flags and adjusts setup
// R13 - Pulses one and four are subtract
// R14 - Counters reset on clear, saturate
`timescale 1ns/1ps
`include "ablm_defs.svh"
module ablm_monitor
  import ablm_pkg::*;
#(
  parameter int ADC_W = 14
)(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic FLOAT_LED_MODE,
  input wire logic SAMPLE_VALID,
  input wire logic SAMPLE_SLOT_B,
  input wire logic [1:0] SAMPLE_CHAN,
  input wire logic [1:0] SAMPLE_PULSE,
  input wire logic [ADC_W-1:0] SAMPLE_RAW,
  input wire logic INT_IN,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  output logic [15:0] REG_RDATA,
  output logic [7:0] AMBIENT_EXCEED_FLAGS,
  output logic GENERAL_PURPOSE_PIN0,
  output logic GENERAL_PURPOSE_PIN1
);
  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [15:0] alt_q;
  logic [15:0] limit_a_q;
  logic [15:0] limit_b_q;
  logic [15:0] math_q;
  logic [ADC_W-1:0] ofs_q [0:7];
  logic [7:0] flags_q;
  ablm_count_t cnt_q [0:7];
  logic clr_rd;
  ablm_flag_if fi ();
  // Decoded offset slot of the current bus address
  logic [3:0] ofs_idx;

  // Offset register index decode, 0..7 or 8 for none
  function automatic logic [3:0] ofs_index(input logic [7:0] a);
    logic [3:0] r;
    r = 4'h8;
    if (a >= `ABLM_ADDR_OFS_A0 && a < `ABLM_ADDR_OFS_A0 + 8'h04) r = {2'b00, a[1:0] - 2'b00};
    if (a >= `ABLM_ADDR_OFS_B0 && a < `ABLM_ADDR_OFS_B0 + 8'h04) begin
      r = 4'h4 + {2'b00, 2'(a - `ABLM_ADDR_OFS_B0)};
    end
    if (a >= `ABLM_ADDR_OFS_A0 && a < `ABLM_ADDR_OFS_A0 + 8'h04) begin
      r = {2'b00, 2'(a - `ABLM_ADDR_OFS_A0)};
    end
    return r;
  endfunction : ofs_index
  assign ofs_idx = ofs_index(REG_ADDR);

  // Limit threshold for a count code, 0 meaning never
  function automatic ablm_count_t limit_of(input logic [1:0] code);
    ablm_count_t r;
    r = 5'h00;
    unique case (ablm_limit_t'(code))
      ABLM_NEVER: r = 5'h00;
      ABLM_ONCE: r = 5'h01;
      ABLM_FOUR: r = `ABLM_LIM_CODE2;
      ABLM_SIXTEEN: r = `ABLM_LIM_CODE3;
    endcase
    return r;
  endfunction : limit_of

  // ----------------------------------------
  // Configuration writes
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      alt_q <= `ABLM_RST_WORD;
      limit_a_q <= `ABLM_RST_WORD;
      limit_b_q <= `ABLM_RST_WORD;
      math_q <= `ABLM_RST_MATH;
    end else if (REG_WR) begin
      unique case (REG_ADDR)
        `ABLM_ADDR_ALT: alt_q <= REG_WDATA;
        `ABLM_ADDR_LIMIT_A: limit_a_q <= REG_WDATA; // R9
        `ABLM_ADDR_LIMIT_B: limit_b_q <= REG_WDATA; // R9
        `ABLM_ADDR_MATH: math_q <= REG_WDATA;
        default: ;
      endcase
    end
  end

  // Offset registers
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < 8; i++) ofs_q[i] <= '0;
    end else if (REG_WR && ofs_idx != 4'h8) begin
      ofs_q[ofs_idx[2:0]] <= REG_WDATA[ADC_W-1:0];
    end
  end

  // ----------------------------------------
  // Read path, status clears on read
  // ----------------------------------------
  // Any status read clears every lane without a hit or fresh crossing that cycle
  assign clr_rd = REG_RD && (REG_ADDR == `ABLM_ADDR_STATUS);

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      REG_RDATA <= 16'h0000;
    end else if (REG_RD) begin
      if (ofs_idx != 4'h8) begin
        REG_RDATA <= 16'(ofs_q[ofs_idx[2:0]]);
      end else begin
        unique case (REG_ADDR)
          `ABLM_ADDR_STATUS: REG_RDATA <= {8'h00, flags_q}; // R7
          `ABLM_ADDR_ALT: REG_RDATA <= alt_q;
          `ABLM_ADDR_LIMIT_A: REG_RDATA <= limit_a_q;
          `ABLM_ADDR_LIMIT_B: REG_RDATA <= limit_b_q;
          `ABLM_ADDR_MATH: REG_RDATA <= math_q;
          default: REG_RDATA <= 16'h0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Per-channel compare, count, flag
  // ----------------------------------------
  // Subtract cycles from the fixed ABLM_SUB_MASK pattern, not math_q, LED masked there
  logic sub_cycle;
  assign sub_cycle = FLOAT_LED_MODE &&
                     (((`ABLM_SUB_MASK >> SAMPLE_PULSE) & 4'h1) != 4'h0); // R1 R13

  // ----------------------------------------
  // Channel lanes
  // ----------------------------------------
  for (genvar g = 0; g < 8; g++) begin : g_chan
    logic hit;
    logic own_lane;
    logic over_thr;
    logic lvl;
    logic lvl_q;
    logic [15:0] lim_reg;
    ablm_count_t lim;
    logic signed [ADC_W+1:0] corr;
    assign lim_reg = (g < 4) ? limit_a_q : limit_b_q;
    assign lim = limit_of(lim_reg[15:`ABLM_CNT_LSB]); // R6
    assign corr = $signed({2'b00, SAMPLE_RAW}) - $signed({2'b00, ofs_q[g]}); // R3
    // Sample belongs to this slot and channel
    assign own_lane = (SAMPLE_SLOT_B == (g >= 4)) && (SAMPLE_CHAN == 2'(g % 4)); // R7
    assign over_thr = corr > $signed({2'b00, lim_reg[`ABLM_THR_MSB:0]}); // R2
    assign hit = SAMPLE_VALID && sub_cycle && own_lane && over_thr; // R2
    // Count at or past the selected limit
    assign lvl = (lim != 5'h00) && (cnt_q[g] >= lim); // R5

    // Counter saturates, clears with its flag
    always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
        cnt_q[g] <= 5'h00;
      end else if (hit && cnt_q[g] != 5'h1F) begin
        cnt_q[g] <= cnt_q[g] + 5'h01; // R4 R14
      end else if (clr_rd) begin
        cnt_q[g] <= 5'h00; // R14
      end
    end

    // Previous limit level, so a count parked at the limit sets only once
    always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
        lvl_q <= 1'b0;
      end else begin
        lvl_q <= lvl;
      end
    end

    // Sticky flag; a fresh crossing wins over read clear
    always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
        flags_q[g] <= 1'b0;
      end else if (lvl && !lvl_q) begin
        flags_q[g] <= 1'b1; // R5
      end else if (clr_rd) begin
        flags_q[g] <= 1'b0; // R8
      end
    end
  end

  // ----------------------------------------
  // Pin routing
  // ----------------------------------------
  assign fi.flags = flags_q;
  assign fi.irq = INT_IN;
  assign fi.alt_sel = alt_q;

  ablm_pin_mux u_mux (
    .clk(CLK),
    .rst_n(RSTN),
    .fi(fi.mux)
  );

  // Flag and pin outputs
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      AMBIENT_EXCEED_FLAGS <= 8'h00;
    end else begin
      AMBIENT_EXCEED_FLAGS <= flags_q;
    end
  end
  // Pin levels are already registered inside the mux
  assign GENERAL_PURPOSE_PIN0 = fi.pin0; // R10
  assign GENERAL_PURPOSE_PIN1 = fi.pin1; // R11
endmodule : ablm_monitor

/* File: testbench/ablm_host.sv */
`timescale 1ns/1ps
// --------------------
// Host register master
// --------------------
module ablm_host (
  input wire logic CLK,
  input wire logic [15:0] REG_RDATA,
  output logic REG_WR = 1'h0,
  output logic REG_RD = 1'h0,
  output logic [7:0] REG_ADDR = 8'h00,
  output logic [15:0] REG_WDATA = 16'h0000
);
  // One write strobe, then address and data turned round
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge CLK);
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WR = 1'h1;
    @(negedge CLK);
    REG_WR = 1'h0;
    REG_ADDR = ~a;
    REG_WDATA = ~d;
  endtask : wr
  // Poll a register; data taken after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge CLK);
    REG_ADDR = a;
    REG_RD = 1'h1;
    @(negedge CLK);
    REG_RD = 1'h0;
    REG_ADDR = ~a;
    d = REG_RDATA;
  endtask : rd
endmodule : ablm_host

/* File: testbench/ablm_monitor_properties.sv */
`timescale 1ns/1ps
module ablm_monitor_checker
  import ablm_pkg::*;
#(parameter int ADC_W = 14) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic FLOAT_LED_MODE,
  input wire logic SAMPLE_VALID,
  input wire logic [1:0] SAMPLE_PULSE,
  input wire logic INT_IN,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [15:0] REG_RDATA,
  input wire logic [7:0] AMBIENT_EXCEED_FLAGS,
  input wire logic GENERAL_PURPOSE_PIN0,
  input wire logic GENERAL_PURPOSE_PIN1
);
  // Status read, subtract-pulse sample, sample in float mode
  wire logic rd_st = REG_RD && (REG_ADDR == 8'h04);
  wire logic sub = SAMPLE_VALID && (SAMPLE_PULSE == 2'h0 || SAMPLE_PULSE == 2'h3);
  wire logic flt = SAMPLE_VALID && FLOAT_LED_MODE;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  stat_upper_a: assert property (rd_st |=> REG_RDATA[15:8] == 8'h00)
    else $error("status upper byte not zero");
  unmapped_rd_a: assert property (REG_RD && REG_ADDR == 8'h05 |=> REG_RDATA == 16'h0000)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!REG_RD |=> $stable(REG_RDATA))
    else $error("read data changed without read");
  flag_rise_a: assert property (|(AMBIENT_EXCEED_FLAGS & ~$past(AMBIENT_EXCEED_FLAGS))
    |-> $past(sub, 2) || $past(sub, 3) || $past(sub, 4)) else $error("flag set without subtract");
  mode_gate_a: assert property (|(AMBIENT_EXCEED_FLAGS & ~$past(AMBIENT_EXCEED_FLAGS))
    |-> $past(flt, 2) || $past(flt, 3) || $past(flt, 4)) else $error("flag set out of mode");
  flag_sticky_a: assert property (|(~AMBIENT_EXCEED_FLAGS & $past(AMBIENT_EXCEED_FLAGS))
    |-> $past(rd_st, 1) || $past(rd_st, 2) || $past(rd_st, 3)) else $error("flag lost unread");
  pin0_idle_a: assert property (AMBIENT_EXCEED_FLAGS == 8'h00 && !INT_IN && !$past(INT_IN)
    |-> !GENERAL_PURPOSE_PIN0) else $error("pin0 high without cause");
  pin1_idle_a: assert property (AMBIENT_EXCEED_FLAGS == 8'h00 && !INT_IN && !$past(INT_IN)
    |-> !GENERAL_PURPOSE_PIN1) else $error("pin1 high without cause");
endmodule : ablm_monitor_checker
bind ablm_monitor ablm_monitor_checker #(.ADC_W(ADC_W)) ablm_monitor_checker_inst (
  .CLK(CLK), .RSTN(RSTN), .FLOAT_LED_MODE(FLOAT_LED_MODE), .SAMPLE_VALID(SAMPLE_VALID),
  .SAMPLE_PULSE(SAMPLE_PULSE), .INT_IN(INT_IN), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
  .REG_RDATA(REG_RDATA), .AMBIENT_EXCEED_FLAGS(AMBIENT_EXCEED_FLAGS),
  .GENERAL_PURPOSE_PIN0(GENERAL_PURPOSE_PIN0), .GENERAL_PURPOSE_PIN1(GENERAL_PURPOSE_PIN1));

/* File: testbench/ablm_monitor_tb.sv */
`timescale 1ns/1ps
`include "ablm_defs.svh"
module ablm_monitor_tb
  import ablm_pkg::*;
;
  logic clk = 1'h0, rstn = 1'h0, mode = 1'h0, sv = 1'h0, sb = 1'h0, intr = 1'h0;
  logic wr, rd, p0, p1;
  logic [1:0] ch = 2'h0, pu = 2'h0;
  logic [13:0] raw = 14'h0000;
  logic [7:0] addr, flags;
  logic [15:0] wdata, rdata, d;
  int n_checks = 0, n_mismatch = 0;
  always #2 clk = ~clk;
  ablm_monitor ablm_monitor_inst (.CLK(clk), .RSTN(rstn), .FLOAT_LED_MODE(mode),
    .SAMPLE_VALID(sv), .SAMPLE_SLOT_B(sb), .SAMPLE_CHAN(ch), .SAMPLE_PULSE(pu),
    .SAMPLE_RAW(raw), .INT_IN(intr), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .AMBIENT_EXCEED_FLAGS(flags),
    .GENERAL_PURPOSE_PIN0(p0), .GENERAL_PURPOSE_PIN1(p1));
  ablm_host ablm_host_inst (.CLK(clk), .REG_RDATA(rdata), .REG_WR(wr), .REG_RD(rd),
    .REG_ADDR(addr), .REG_WDATA(wdata));
  // ------------------
  // Compare and stimulus
  // ------------------
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [15:0] e, input string n);
    ablm_host_inst.rd(a, d);
    chk(n, e, d);
  endtask : rdc
  // One sample pulse, then wait out the flag latency
  task automatic smp(input logic b, input logic [1:0] c, p, input logic [13:0] r);
    @(negedge clk);
    sb = b;
    ch = c;
    pu = p;
    raw = r;
    sv = 1'h1;
    @(negedge clk);
    sv = 1'h0;
    raw = ~r;
    repeat (3) @(negedge clk);
  endtask : smp
  task automatic t_once;
    ablm_host_inst.wr(`ABLM_ADDR_LIMIT_A, 16'h4100);
    rdc(`ABLM_ADDR_LIMIT_A, 16'h4100, "limit_a");
    rdc(8'h05, 16'h0000, "unmapped");
    ablm_host_inst.wr(`ABLM_ADDR_OFS_A0 + 8'h02, 16'h0010);
    smp(1'h0, 2'h2, 2'h0, 14'h0111);
    mode = 1'h1;
    smp(1'h0, 2'h2, 2'h0, 14'h0110);
    smp(1'h0, 2'h2, 2'h1, 14'h3FFF);
    chk("flags_miss", 16'h0000, {8'h00, flags});
    smp(1'h0, 2'h2, 2'h3, 14'h0111);
    chk("flags_once", 16'h0004, {8'h00, flags});
    rdc(`ABLM_ADDR_STATUS, 16'h0004, "status");
    rdc(`ABLM_ADDR_STATUS, 16'h0000, "status_clr");
    $display("test once done");
  endtask : t_once
  task automatic t_four;
    ablm_host_inst.wr(`ABLM_ADDR_LIMIT_B, 16'h8200);
    repeat (3) smp(1'h1, 2'h0, 2'h3, 14'h0201);
    chk("flags_three", 16'h0000, {8'h00, flags});
    smp(1'h1, 2'h0, 2'h0, 14'h0201);
    chk("flags_four", 16'h0010, {8'h00, flags});
    $display("test four done");
  endtask : t_four
  task automatic t_pins;
    ablm_host_inst.wr(`ABLM_ADDR_ALT, 16'h1A10);
    repeat (2) @(negedge clk);
    chk("pins_slot", 16'h0002, {14'h0000, p1, p0});
    rdc(`ABLM_ADDR_STATUS, 16'h0010, "status_b");
    intr = 1'h1;
    ablm_host_inst.wr(`ABLM_ADDR_ALT, 16'h1C1B);
    repeat (2) @(negedge clk);
    chk("pins_int", 16'h0002, {14'h0000, p1, p0});
    intr = 1'h0;
    $display("test pins done");
  endtask : t_pins
  task automatic t_codes;
    ablm_host_inst.wr(`ABLM_ADDR_LIMIT_A, 16'h0100);
    repeat (4) smp(1'h0, 2'h0, 2'h0, 14'h0101);
    chk("flags_never", 16'h0000, {8'h00, flags});
    ablm_host_inst.wr(`ABLM_ADDR_LIMIT_A, 16'hC100);
    rdc(`ABLM_ADDR_STATUS, 16'h0000, "status_never");
    repeat (15) smp(1'h0, 2'h0, 2'h3, 14'h0101);
    chk("flags_fifteen", 16'h0000, {8'h00, flags});
    smp(1'h0, 2'h0, 2'h0, 14'h0101);
    chk("flags_sixteen", 16'h0001, {8'h00, flags});
    rdc(`ABLM_ADDR_STATUS, 16'h0001, "status_sixteen");
    $display("test codes done");
  endtask : t_codes
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  initial begin
    repeat (4) @(negedge clk);
    rstn = 1'h1;
    t_once();
    t_four();
    t_pins();
    t_codes();
    summarize();
  end
  initial begin
    #100000;
    n_mismatch++;
    summarize();
  end
endmodule : ablm_monitor_tb
